// ---- mswt_table.sv ----
`timescale 1ns/1ps
// Function
// R1: Word three holds differences, entries 96-127
// R2: Word four holds differences, entries 128-159
// R3: Reset loads default sine-wave table contents
// R4: Each bit plus offset code gives difference
// R5: Zero bit gives code minus one
// R6: One bit gives code plus zero
// R7: Bit n is nth difference, LSB first
// R8: Position zero loads both start values
// R9: Entries accumulate decoded differences in order
module mswt_table (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // APB slave
  input wire logic [mswt_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Counter, segment code and neighbouring table bit
  input wire logic [7:0] microstep_counter,
  input wire logic [1:0] segment_offset_select,
  input wire logic other_delta_bit,
  // Start values for counter position zero
  input wire logic [mswt_pkg::START_W-1:0] coil_a_start_value,
  input wire logic [mswt_pkg::START_W-1:0] coil_b_start_value,
  // Wave outputs
  output logic signed [mswt_pkg::WAVE_W-1:0] coil_a_current,
  output logic signed [mswt_pkg::WAVE_W-1:0] coil_b_current,
  output logic table_hit
);

  logic [31:0] wave_delta_word_three;
  logic [31:0] wave_delta_word_four;
  logic [7:0] prev_count;
  logic setup_phase;
  logic access_phase;
  logic addr_three;
  logic addr_four;
  logic addr_status;
  logic step_fwd;
  logic step_back;
  logic [7:0] bit_index;
  logic own_bit;
  logic own_hit;
  logic signed [mswt_pkg::WAVE_W-1:0] inc_ext;
  logic signed [mswt_pkg::WAVE_W-1:0] next_coil_a;
  logic [31:0] status_word;
  logic [31:0] read_mux;

  mswt_dec_if dec ();

  mswt_delta_decoder u_dec (
    .dec(dec.decoder)
  );

  // Bus phase and address decode
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign addr_three = (paddr == mswt_pkg::ADDR_WORD_THREE);
  assign addr_four = (paddr == mswt_pkg::ADDR_WORD_FOUR);
  assign addr_status = (paddr == mswt_pkg::ADDR_WAVE_STATUS);
  assign pready = 1'b1; // Zero wait states

  // Word three: byte-enabled write, sine reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wave_delta_word_three <= mswt_pkg::RST_WORD_THREE; // R3
    end else if (access_phase && pwrite && addr_three) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          wave_delta_word_three[8*b +: 8] <= pwdata[8*b +: 8]; // R1
        end
      end
    end
  end

  // Word four: byte-enabled write, sine reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wave_delta_word_four <= mswt_pkg::RST_WORD_FOUR; // R3
    end else if (access_phase && pwrite && addr_four) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          wave_delta_word_four[8*b +: 8] <= pwdata[8*b +: 8]; // R2
        end
      end
    end
  end

  // Read-only status: current wave value, last counter, hit flag
  always_comb begin
    status_word = 32'h0;
    status_word[mswt_pkg::STAT_VALUE_LSB +: mswt_pkg::WAVE_W] = coil_a_current;
    status_word[mswt_pkg::STAT_COUNT_LSB +: 8] = prev_count;
    status_word[mswt_pkg::STAT_HIT_BIT] = table_hit;
  end

  // Read selection
  always_comb begin
    if (addr_three) begin
      read_mux = wave_delta_word_three;
    end else if (addr_four) begin
      read_mux = wave_delta_word_four;
    end else if (addr_status) begin
      read_mux = status_word;
    end else begin
      read_mux = 32'h0;
    end
  end

  // Read data and error captured in setup, shown in access
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0 : read_mux;
      pslverr <= !(addr_three || addr_four || (addr_status && !pwrite));
    end
  end

  // Step direction against the last counter value
  assign step_fwd = (microstep_counter == prev_count + 8'h01);
  assign step_back = (microstep_counter == prev_count - 8'h01);
  // Difference between entry x and x+1 is bit x
  assign bit_index = step_fwd ? prev_count : microstep_counter;

  // Pick bit n of the owning word, LSB first
  always_comb begin
    own_hit = 1'b1;
    case (bit_index[7:5])
      mswt_pkg::SEG_WORD_THREE: own_bit = wave_delta_word_three[bit_index[4:0]]; // R7
      mswt_pkg::SEG_WORD_FOUR: own_bit = wave_delta_word_four[bit_index[4:0]]; // R7
      default: begin
        own_bit = other_delta_bit;
        own_hit = 1'b0;
      end
    endcase
  end

  // Bit and segment code to the decoder
  assign dec.delta_bit = own_bit; // R4
  assign dec.offset_code = segment_offset_select; // R4
  assign inc_ext = {{(mswt_pkg::WAVE_W-3){dec.increment[2]}}, dec.increment};

  // Next wave value: start at zero, else running sum
  always_comb begin
    if (microstep_counter == mswt_pkg::COUNT_ORIGIN) begin
      next_coil_a = $signed({1'b0, coil_a_start_value}); // R8
    end else if (step_fwd) begin
      next_coil_a = coil_a_current + inc_ext; // R9
    end else if (step_back) begin
      next_coil_a = coil_a_current - inc_ext; // R9
    end else begin
      next_coil_a = coil_a_current;
    end
  end

  // Coil A wave value and counter tracking
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      coil_a_current <= '0;
      prev_count <= 8'h00;
      table_hit <= 1'b0;
    end else begin
      coil_a_current <= next_coil_a;
      prev_count <= microstep_counter;
      table_hit <= own_hit && (step_fwd || step_back);
    end
  end

  // Coil B start value at counter position zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      coil_b_current <= '0;
    end else if (microstep_counter == mswt_pkg::COUNT_ORIGIN) begin
      coil_b_current <= $signed({1'b0, coil_b_start_value}); // R8
    end
  end

endmodule

// ---- mswt_pkg.sv ----
package mswt_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_WORD_THREE = 8'h63;
  localparam logic [7:0] IDX_WORD_FOUR = 8'h64;
  localparam logic [7:0] IDX_WAVE_STATUS = 8'h6a;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_WORD_THREE = {2'h0, IDX_WORD_THREE, 2'h0};
  localparam logic [11:0] ADDR_WORD_FOUR = {2'h0, IDX_WORD_FOUR, 2'h0};
  localparam logic [11:0] ADDR_WAVE_STATUS = {2'h0, IDX_WAVE_STATUS, 2'h0};

  // Reset contents of the two table words (sine wave)
  localparam logic [31:0] RST_WORD_THREE = 32'h10104222;
  localparam logic [31:0] RST_WORD_FOUR = 32'hfbffffff;

  // Table segment covered by each word, by counter bits 7:5
  localparam logic [2:0] SEG_WORD_THREE = 3'h3;
  localparam logic [2:0] SEG_WORD_FOUR = 3'h4;
  localparam logic [7:0] COUNT_ORIGIN = 8'h00;

  // Wave value width and status field positions
  localparam int WAVE_W = 9;
  localparam int START_W = 8;
  localparam int STAT_VALUE_LSB = 0;
  localparam int STAT_COUNT_LSB = 16;
  localparam int STAT_HIT_BIT = 24;

  typedef logic signed [2:0] mswt_inc_t;

endpackage

// ---- mswt_dec_if.sv ----
`timescale 1ns/1ps
interface mswt_dec_if;
  logic delta_bit;
  logic [1:0] offset_code;
  mswt_pkg::mswt_inc_t increment;

  modport requester (output delta_bit, output offset_code, input increment);
  modport decoder (input delta_bit, input offset_code, output increment);
endinterface

// ---- mswt_delta_decoder.sv ----
`timescale 1ns/1ps
module mswt_delta_decoder (
  // Difference bit and offset code in, signed step out
  mswt_dec_if.decoder dec
);

  // Code minus one, plus one more when the bit is set
  always_comb begin
    dec.increment = $signed({1'b0, dec.offset_code}) - 3'sd1 + $signed({2'b00, dec.delta_bit}); // R5 R6
  end

endmodule

// ---- mswt_table_asserts.sv ----
`timescale 1ns/1ps
module mswt_table_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Watched ports
  input wire logic pready,
  input wire logic [7:0] microstep_counter,
  input wire logic [1:0] segment_offset_select,
  input wire logic other_delta_bit,
  input wire logic [7:0] coil_a_start_value,
  input wire logic [7:0] coil_b_start_value,
  input wire logic signed [8:0] coil_a_current,
  input wire logic signed [8:0] coil_b_current,
  input wire logic table_hit
);
  logic [7:0] c;
  logic signed [8:0] inc, up, dn;
  // Expected step from a neighbour bit
  assign c = microstep_counter;
  assign inc = {7'h0, segment_offset_select} + {8'h0, other_delta_bit} - 9'h1;
  assign up = coil_a_current + inc;
  assign dn = coil_a_current - inc;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_loada; c == 8'h0 |=> coil_a_current == {1'b0, $past(coil_a_start_value)}; endproperty
  a_loada: assert property (p_loada) else $error("coil a not loaded");
  property p_loadb; c == 8'h0 |=> coil_b_current == {1'b0, $past(coil_b_start_value)}; endproperty
  a_loadb: assert property (p_loadb) else $error("coil b not loaded");
  property p_up; c == $past(c) + 8'h1 && c != 8'h0 && ($past(c) < 8'h60 || $past(c) > 8'h9f)
    |=> coil_a_current == $past(up); endproperty
  a_up: assert property (p_up) else $error("bad forward step");
  property p_dn; c + 8'h1 == $past(c) && c != 8'h0 && (c < 8'h60 || c > 8'h9f)
    |=> coil_a_current == $past(dn); endproperty
  a_dn: assert property (p_dn) else $error("bad backward step");
  property p_hold; c != 8'h0 && c != $past(c) + 8'h1 && c + 8'h1 != $past(c)
    |=> $stable(coil_a_current); endproperty
  a_hold: assert property (p_hold) else $error("coil a moved");
  property p_bhold; c != 8'h0 |=> $stable(coil_b_current); endproperty
  a_bhold: assert property (p_bhold) else $error("coil b moved");
  property p_hit; c == $past(c) + 8'h1 && c != 8'h0
    |=> table_hit == ($past(c, 2) >= 8'h60 && $past(c, 2) <= 8'h9f); endproperty
  a_hit: assert property (p_hit) else $error("table hit wrong");
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, other_delta_bit = 0, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] microstep_counter = 8'h0, coil_a_start_value = 8'h10, coil_b_start_value = 8'h25;
  logic [1:0] segment_offset_select = 2'h1;
  wire [31:0] prdata;
  wire pready, pslverr, table_hit;
  wire signed [8:0] coil_a_current, coil_b_current;
  int fail_count = 0, n_compared = 0;
  // Clock
  always #25 sys_clk = ~sys_clk;
  mswt_table i_mswt_table (.sys_clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .microstep_counter, .segment_offset_select,
    .other_delta_bit, .coil_a_start_value, .coil_b_start_value, .coil_a_current,
    .coil_b_current, .table_hit);
  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer, setup then access until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 16) begin
      fail_count++;
      final_report;
    end
  endtask
  task automatic t_regs;
    apb(0, mswt_pkg::ADDR_WORD_THREE, 0); chk("three rst", rd, mswt_pkg::RST_WORD_THREE);
    apb(0, mswt_pkg::ADDR_WORD_FOUR, 0); chk("four rst", rd, mswt_pkg::RST_WORD_FOUR);
    apb(1, mswt_pkg::ADDR_WORD_THREE, 32'h000000ff);
    pstrb <= 4'h2;
    apb(1, mswt_pkg::ADDR_WORD_THREE, 32'hffffab00);
    pstrb <= 4'hf;
    apb(1, mswt_pkg::ADDR_WORD_FOUR, 32'h80000001);
    apb(1, 12'h004, 32'hffffffff); chk("unmapped", {31'h0, err}, 32'h1);
    apb(0, mswt_pkg::ADDR_WORD_THREE, 0); chk("three", rd, 32'h0000abff);
    apb(0, mswt_pkg::ADDR_WORD_FOUR, 0); chk("four", rd, 32'h80000001);
  endtask
  task automatic t_walk;
    repeat (2) @(posedge sys_clk);
    chk("a start", {23'h0, coil_a_current}, 32'h10);
    chk("b start", {23'h0, coil_b_current}, 32'h25);
    for (int i = 1; i < 162; i++) begin
      @(posedge sys_clk);
      microstep_counter <= 8'(i);
    end
    repeat (2) @(posedge sys_clk);
    chk("a walk", {23'h0, coil_a_current}, 32'h1f);
    segment_offset_select <= 2'h0;
    microstep_counter <= 8'ha0;
    repeat (2) @(posedge sys_clk);
    chk("a back", {23'h0, coil_a_current}, 32'h20);
    microstep_counter <= 8'h05;
    repeat (2) @(posedge sys_clk);
    chk("a jump", {23'h0, coil_a_current}, 32'h20);
    apb(0, mswt_pkg::ADDR_WAVE_STATUS, 0); chk("status", rd, 32'h00050020);
    apb(1, mswt_pkg::ADDR_WAVE_STATUS, 0); chk("status wr", {31'h0, err}, 32'h1);
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs;
    t_walk;
    final_report;
  end
endmodule
bind mswt_table mswt_table_asserts i_chk (.sys_clk, .nrst, .pready, .microstep_counter,
  .segment_offset_select, .other_delta_bit, .coil_a_start_value, .coil_b_start_value,
  .coil_a_current, .coil_b_current, .table_hit);
